// [src/trim_clamp_pkg.sv]
// shared constants and types of the trim, clamp and coil diagnostic block
package trim_clamp_pkg;
   // register offsets
   localparam logic [7:0] CLAMP_OFS = 8'h08;
   localparam logic [7:0] DIAG_OFS  = 8'h09;
   localparam logic [7:0] CTRL_OFS  = 8'h0a;
   localparam logic [7:0] STAT_OFS  = 8'h0b;
   localparam logic [7:0] TRIM_OFS  = 8'h13;
   // field positions
   localparam int HI_LSB = 0;
   localparam int LO_LSB = 12;
   localparam int SENS_LSB = 0;
   localparam int QVO_LSB = 12;
   localparam int FREQ_LSB = 13;
   localparam int OV_BIT = 0;
   localparam int UV_BIT = 1;
   localparam int BIST_BIT = 2;
   localparam int SOR_BIT = 3;
   localparam int COIL_BIT = 4;
   localparam int MODE_BIT = 5;
   localparam int CBDIS_BIT = 6;
   localparam int CCDIS_BIT = 7;
   localparam int REQ_BIT = 0;
   localparam int STATE_LSB = 5;
   // reset values
   localparam logic [23:0] CLAMP_RST = 24'h000fff;
   localparam logic [23:0] TRIM_RST  = 24'h000000;
   localparam logic [23:0] DIAG_RST  = 24'h006000;
   // timing
   localparam int CLK_HZ   = 20_000_000;
   localparam int SWAP_HZ  = 128_000;
   localparam int OUT_HZ   = 16_000;
   localparam int CHECK_HZ = 8_000;
   localparam int ON_MS    = 16;
   localparam int OFF1_MS  = 16;
   localparam int OFF2_MS  = 4080;
   localparam int SWAP_CYC  = CLK_HZ / SWAP_HZ / 2;
   localparam int OUT_CYC   = CLK_HZ / OUT_HZ;
   localparam int CHECK_CYC = CLK_HZ / CHECK_HZ;
   localparam int ON_CYC    = CLK_HZ / 1000 * ON_MS;
   localparam int OFF1_CYC  = CLK_HZ / 1000 * OFF1_MS;
   localparam int OFF2_CYC  = CLK_HZ / 1000 * OFF2_MS;
   localparam logic [1:0] FREQ_OFF = 2'h3;

   typedef enum logic [1:0] {COIL_IDLE, COIL_ON, COIL_OFF} coil_state_t;
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [7:0]  addr;
      logic [23:0] wdata;
   } bus_req_t;
   typedef struct packed {
      logic        valid;
      logic        err;
      logic        hiz;
      logic [11:0] data;
   } enc_out_t;
endpackage

// [src/output_trim_clamp_diag.sv]
// post-linearization trim, output clamp and coil self-test scheduler
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/10ps
module output_trim_clamp_diag
   import trim_clamp_pkg::*;
#(
   parameter int unsigned ON_CYCLES   = ON_CYC,
   parameter int unsigned OFF1_CYCLES = OFF1_CYC,
   parameter int unsigned OFF2_CYCLES = OFF2_CYC
) (
   // clock and reset
   input  wire logic               i_sys_clk,
   input  wire logic               i_rst,
   // register port
   input  wire bus_req_t           i_bus,
   output logic             [23:0] o_rd_data,
   // sample path
   input  wire logic signed [12:0] i_linearized_sample,
   output enc_out_t                o_out,
   // fault detectors
   input  wire logic               i_ov_det,
   input  wire logic               i_uv_det,
   input  wire logic               i_bist_err,
   input  wire logic               i_adc_over,
   // coil diagnostic analog path
   input  wire logic        [11:0] i_coil_resp,
   input  wire logic        [11:0] i_coil_ref,
   output logic                    o_coil_on,
   output logic                    o_diag_sel,
   output logic                    o_comp_en
);

   logic        [23:0] clamp_reg;
   logic        [23:0] trim_reg;
   logic        [23:0] diag_reg;
   logic        [4:0]  stat_reg;
   logic        [4:0]  stat_next;
   logic               req_reg;
   coil_state_t        coil_reg;
   logic        [31:0] coil_cnt_reg;
   logic        [15:0] out_cnt_reg;
   logic        [15:0] chk_cnt_reg;
   logic        [7:0]  swap_cnt_reg;
   logic signed [11:0] trimmed_sample_reg;

   // decoded fields
   logic signed [11:0] sens;
   logic signed [11:0] qvo;
   logic        [11:0] clamp_hi;
   logic        [11:0] clamp_lo;
   logic        [1:0]  coil_freq;
   assign sens      = trim_reg[SENS_LSB +: 12];
   assign qvo       = trim_reg[QVO_LSB +: 12];
   assign clamp_hi  = clamp_reg[HI_LSB +: 12];
   assign clamp_lo  = clamp_reg[LO_LSB +: 12];
   assign coil_freq = diag_reg[FREQ_LSB +: 2];

   function automatic logic hit(input bus_req_t b,
                                input logic [7:0] ofs);
      hit = b.wr && (b.addr == ofs);
   endfunction

   // register writes
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         clamp_reg <= CLAMP_RST;
         trim_reg  <= TRIM_RST;
         diag_reg  <= DIAG_RST;
      end else begin
         if (hit(i_bus, CLAMP_OFS)) begin
            clamp_reg <= i_bus.wdata;
         end
         if (hit(i_bus, TRIM_OFS)) begin
            trim_reg <= i_bus.wdata;
         end
         if (hit(i_bus, DIAG_OFS)) begin
            diag_reg <= i_bus.wdata;
         end
      end
   end

   // self-test request, consumed when the coil starts
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         req_reg <= 1'b0;
      end else if (hit(i_bus, CTRL_OFS) && i_bus.wdata[REQ_BIT]) begin
         req_reg <= 1'b1;
      end else if (coil_reg == COIL_ON) begin
         req_reg <= 1'b0;
      end
   end

   // register reads, data valid in the next cycle only
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         o_rd_data <= 24'h000000;
      end else if (!i_bus.rd) begin
         o_rd_data <= 24'h000000;
      end else begin
         case (i_bus.addr)
            CLAMP_OFS: o_rd_data <= clamp_reg;
            TRIM_OFS:  o_rd_data <= trim_reg;
            DIAG_OFS:  o_rd_data <= diag_reg;
            CTRL_OFS:  o_rd_data <= {23'h000000, req_reg};
            STAT_OFS:  o_rd_data <= {17'h00000, coil_reg, stat_reg};
            default:   o_rd_data <= 24'h000000;
         endcase
      end
   end

   // trim stage
   logic signed [24:0] prod;
   logic signed [14:0] sum;
   logic signed [11:0] sat;
   always_comb begin
      prod = i_linearized_sample * sens;
      // a part-select is unsigned, so the product is re-signed first
      sum  = 15'(i_linearized_sample) + 15'($signed(prod[24:11]))
             + 15'(qvo);
      if (sum > 15'sd2047) begin
         sat = 12'sh7ff;
      end else if (sum < -15'sd2048) begin
         sat = 12'sh800;
      end else begin
         sat = sum[11:0];
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         trimmed_sample_reg <= 12'sh000;
      end else begin
         trimmed_sample_reg <= sat;
      end
   end

   // clamp stage
   logic [11:0] unsigned_sample;
   logic [11:0] clamped_sample;
   logic        clamped;
   always_comb begin
      // adding 2048 to a 12-bit signed value only flips the sign bit
      unsigned_sample = {~trimmed_sample_reg[11],
                         trimmed_sample_reg[10:0]};
      clamped = 1'b1;
      if (unsigned_sample > clamp_hi) begin
         clamped_sample = clamp_hi;
      end else if (unsigned_sample < clamp_lo) begin
         clamped_sample = clamp_lo;
      end else begin
         clamped_sample = unsigned_sample;
         clamped = 1'b0;
      end
   end

   // timebases
   logic out_tick;
   logic chk_tick;
   assign out_tick = out_cnt_reg == 16'(OUT_CYC - 1);
   assign chk_tick = chk_cnt_reg == 16'(CHECK_CYC - 1);
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         out_cnt_reg <= 16'h0000;
      end else begin
         out_cnt_reg <= out_tick ? 16'h0000 : out_cnt_reg + 16'h0001;
      end
   end
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         chk_cnt_reg <= 16'h0000;
      end else begin
         chk_cnt_reg <= chk_tick ? 16'h0000 : chk_cnt_reg + 16'h0001;
      end
   end

   // coil scheduler
   logic [31:0] off_len;
   logic        on_done;
   always_comb begin
      case (coil_freq)
         2'h1:    off_len = 32'(OFF1_CYCLES);
         2'h2:    off_len = 32'(OFF2_CYCLES);
         default: off_len = 32'h00000000;
      endcase
   end
   assign on_done = coil_cnt_reg == 32'(ON_CYCLES - 1);

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         coil_reg     <= COIL_IDLE;
         coil_cnt_reg <= 32'h00000000;
      end else begin
         coil_cnt_reg <= coil_cnt_reg + 32'h00000001;
         case (coil_reg)
            COIL_IDLE: begin
               coil_cnt_reg <= 32'h00000000;
               if (coil_freq != FREQ_OFF || req_reg) begin
                  coil_reg <= COIL_ON;
               end
            end
            COIL_ON: begin
               if (on_done) begin
                  coil_cnt_reg <= 32'h00000000;
                  if (coil_freq == FREQ_OFF) begin
                     coil_reg <= COIL_IDLE;
                  end else if (off_len != 32'h00000000) begin
                     coil_reg <= COIL_OFF;
                  end
               end
            end
            COIL_OFF: begin
               if (coil_freq == FREQ_OFF) begin
                  coil_reg <= COIL_IDLE;
               // off length 0 written mid-off must end the off-period now
               end else if (coil_cnt_reg + 32'h00000001 >= off_len) begin
                  coil_reg     <= COIL_ON;
                  coil_cnt_reg <= 32'h00000000;
               end
            end
            default: coil_reg <= COIL_IDLE;
         endcase
      end
   end

   // path time-sharing; only the diagnostic slot sees the coil field
   logic coil_active;
   assign coil_active = coil_reg == COIL_ON;
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         swap_cnt_reg <= 8'h00;
         o_diag_sel   <= 1'b0;
      end else if (!coil_active) begin
         swap_cnt_reg <= 8'h00;
         o_diag_sel   <= 1'b0;
      end else if (swap_cnt_reg == 8'(SWAP_CYC - 1)) begin
         swap_cnt_reg <= 8'h00;
         o_diag_sel   <= ~o_diag_sel;
      end else begin
         swap_cnt_reg <= swap_cnt_reg + 8'h01;
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         o_coil_on <= 1'b0;
         o_comp_en <= 1'b0;
      end else begin
         o_coil_on <= coil_active;
         o_comp_en <= coil_active && !diag_reg[CCDIS_BIT];
      end
   end

   // deviation check: |resp-ref| > ref/10, done as 10*|diff| > ref
   logic [12:0] dev;
   logic        dev_big;
   always_comb begin
      dev = (i_coil_resp > i_coil_ref) ? 13'(i_coil_resp - i_coil_ref)
                                       : 13'(i_coil_ref - i_coil_resp);
      dev_big = ({dev, 3'b000} + {2'b00, dev, 1'b0})
                > {4'h0, i_coil_ref};
   end

   // sticky faults, write one to clear; a new event wins over the clear
   logic [4:0] clr;
   logic [4:0] evt;
   always_comb begin
      clr = hit(i_bus, STAT_OFS) ? i_bus.wdata[4:0] : 5'h00;
      evt = '0;
      evt[OV_BIT]   = i_ov_det;
      evt[UV_BIT]   = i_uv_det;
      evt[BIST_BIT] = i_bist_err;
      evt[SOR_BIT]  = i_adc_over || (out_tick && clamped);
      evt[COIL_BIT] = chk_tick && coil_active && dev_big;
      stat_next = (stat_reg & ~clr) | evt;
   end
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         stat_reg <= 5'h00;
      end else begin
         stat_reg <= stat_next;
      end
   end

   // error reporting
   logic [4:0] report_en;
   logic       err;
   always_comb begin
      report_en = diag_reg[4:0];
      if (diag_reg[CBDIS_BIT]) begin
         report_en[COIL_BIT] = 1'b0;
      end
      err = |(stat_reg & report_en);
   end

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         o_out <= '0;
      end else begin
         o_out.valid <= out_tick;
         if (out_tick) begin
            o_out.data <= clamped_sample;
            o_out.err  <= err;
            o_out.hiz  <= err && diag_reg[MODE_BIT];
         end
      end
   end

   // checks
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_rst);

   a_out_rate: assert property (o_out.valid |-> $past(out_tick))
      else $error("sample not on output tick");
   a_clamp_high: assert property (o_out.valid && clamp_lo <= clamp_hi
      |-> o_out.data <= $past(clamp_hi))
      else $error("output above upper clamp");
   a_clamp_low: assert property (o_out.valid && clamp_lo <= clamp_hi
      |-> o_out.data >= $past(clamp_lo))
      else $error("output below lower clamp");
   a_unsigned_map: assert property (out_tick && !clamped
      |=> o_out.data == $past(trimmed_sample_reg) + 12'h800)
      else $error("unsigned conversion wrong");
   a_coil_stop: assert property (coil_reg == COIL_IDLE
      |=> !o_coil_on)
      else $error("coil driven while stopped");
   a_on_period: assert property ($rose(o_coil_on)
      |-> o_coil_on[*8])
      else $error("coil on-period cut short");
   a_sel_quiet: assert property (!coil_active
      |=> !o_diag_sel)
      else $error("path swapped outside coil slot");
   a_comp_off: assert property (diag_reg[CCDIS_BIT]
      |=> !o_comp_en)
      else $error("compensation on while disabled");
   a_coil_hide: assert property (diag_reg[CBDIS_BIT]
      && !(|(stat_reg[3:0] & diag_reg[3:0])) && out_tick
      |=> !o_out.err)
      else $error("suppressed coil fault reported");
   a_dev_flag: assert property (chk_tick && coil_active && dev_big
      |=> stat_reg[COIL_BIT])
      else $error("deviation not flagged");

   c_clamp_hit: cover property (out_tick && clamped);
   c_coil_cycle: cover property (coil_reg == COIL_OFF ##1 coil_active);
   c_hiz_out: cover property (o_out.valid && o_out.hiz);
   c_sat_top: cover property (sum > 15'sd2047);

endmodule

// [verif/enc_sink.sv]
// output encoder stand-in: counts frames and checks their spacing
`timescale 1ns/10ps
module enc_sink
   import trim_clamp_pkg::*;
(
   // clock and reset
   input  wire logic     i_sys_clk,
   input  wire logic     i_rst,
   // encoder feed
   input  wire enc_out_t i_out,
   // observations
   output int            o_frames,
   output int            o_gap_err
);
   int gap;

   // the encoder frames at a fixed rate and tolerates no jitter
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         gap       <= 0;
         o_frames  <= 0;
         o_gap_err <= 0;
      end else if (i_out.valid === 1'b1) begin
         gap      <= 1;
         o_frames <= o_frames + 1;
         if (o_frames > 0 && gap != OUT_CYC) begin
            o_gap_err <= o_gap_err + 1;
         end
      end else begin
         gap <= gap + 1;
      end
   end
endmodule

// [verif/output_trim_clamp_diag_tb.sv]
// self-checking bench of the trim, clamp and coil scheduler
`timescale 1ns/10ps
module output_trim_clamp_diag_tb;
   import trim_clamp_pkg::*;
   localparam int ON_N   = 40;
   localparam int OFF1_N = 40;
   localparam int OFF2_N = 80;
   logic               clk     = 1'b0;
   logic               rst     = 1'b1;
   bus_req_t           bus     = '0;
   logic signed [12:0] sample  = '0;
   logic         [3:0] flt     = '0;
   logic        [11:0] resp    = 12'h3e8;
   logic        [11:0] ref_v   = 12'h3e8;
   logic        [23:0] rd_data;
   enc_out_t           out;
   logic               coil_on;
   logic               diag_sel;
   logic               comp_en;
   int                 frames;
   int                 gap_err;
   int                 error_cnt       = 0;
   int                 samples_checked = 0;
   logic        [23:0] v;
   logic        [23:0] trw;
   logic        [23:0] clw;
   logic               lvl;
   int                 n;
   int                 s;
   int                 x;
   int          tx[8] = '{100, -4096, 4095, 1000, 1000, 500, -1900, -1639};
   logic [23:0] tt[8] = '{0, 0, 0, 24'h005800, 24'hffd400, 0, 0, 0};
   logic [23:0] tc[8] = '{24'h000fff, 24'h000fff, 24'h000fff, 24'h000fff,
                          24'h000fff, 24'h100800,
                          24'h199fff, 24'h199e66};
   logic [11:0] dr[4] = '{12'h44c, 12'h44d, 12'h44d, 12'h44d};
   logic [23:0] dw[4] = '{24'h000010, 24'h000010, 24'h000030, 24'h000050};

   always #25 clk = ~clk;

   output_trim_clamp_diag #(.ON_CYCLES(ON_N), .OFF1_CYCLES(OFF1_N),
                            .OFF2_CYCLES(OFF2_N)) dut_u (
      .i_sys_clk(clk), .i_rst(rst), .i_bus(bus), .o_rd_data(rd_data),
      .i_linearized_sample(sample), .o_out(out), .i_ov_det(flt[0]),
      .i_uv_det(flt[1]), .i_bist_err(flt[2]), .i_adc_over(flt[3]),
      .i_coil_resp(resp), .i_coil_ref(ref_v), .o_coil_on(coil_on),
      .o_diag_sel(diag_sel), .o_comp_en(comp_en));

   enc_sink sink_u (.i_sys_clk(clk), .i_rst(rst), .i_out(out),
                    .o_frames(frames), .o_gap_err(gap_err));

   task automatic chk(input string nm, input logic [23:0] seen, exp);
      samples_checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [23:0] d);
      @(posedge clk);
      bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk);
      bus <= '0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [23:0] d);
      @(posedge clk);
      bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 24'h0};
      @(posedge clk);
      bus <= '0;
      #1;
      d = rd_data;
   endtask

   // waits for k output frames, each bounded by 2000 cycles, 1.6 output periods
   task automatic pulses(input int k);
      int w;
      for (int i = 0; i < k; i++) begin
         w = 0;
         do begin
            @(posedge clk);
            #1;
            w++;
         end while (out.valid !== 1'b1 && w < 2000);
         if (w >= 2000) chk("valid", 24'h0, 24'h1);
      end
   endtask

   // length of the current run of the coil level
   task automatic phase(output logic l, output int len);
      l = coil_on;
      len = 0;
      while (coil_on === l && len < 3000) begin
         @(posedge clk);
         #1;
         len++;
      end
   endtask

   function automatic logic [11:0] model(input int x, input logic [23:0] t,
                                         input logic [23:0] c);
      int y;
      y = x + ((x * int'($signed(t[11:0]))) >>> 11) + int'($signed(t[23:12]));
      y = (y > 2047) ? 2047 : (y < -2048) ? -2048 : y;
      y = y + 2048;
      if (y > int'(c[11:0])) y = int'(c[11:0]);
      else if (y < int'(c[23:12])) y = int'(c[23:12]);
      return y[11:0];
   endfunction

   task automatic results;
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   initial begin
      #(95_000 * 50);
      error_cnt++;
      results();
   end

   initial begin
      void'($urandom(93));
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      rd(CLAMP_OFS, v); chk("clamp_rst", v, CLAMP_RST);
      rd(TRIM_OFS, v); chk("trim_rst", v, TRIM_RST);
      rd(DIAG_OFS, v); chk("diag_rst", v, DIAG_RST);
      wr(8'h55, 24'habcdef);
      rd(8'h55, v); chk("unmapped", v, 24'h0);
      // each of the four detector fault sources reports only while its enable is set
      for (int i = 0; i < 4; i++) begin
         wr(DIAG_OFS, DIAG_RST);
         flt[i] <= 1'b1;
         pulses(2); chk("err_masked", out.err, 1'b0);
         wr(DIAG_OFS, DIAG_RST | (24'h1 << i));
         pulses(2); chk("err_set", out.err, 1'b1);
         chk("hiz_off", out.hiz, 1'b0);
         rd(STAT_OFS, v); chk("stat_bit", v[i], 1'b1);
         flt[i] <= 1'b0;
         wr(STAT_OFS, 24'h1f);
         pulses(2); chk("err_clear", out.err, 1'b0);
      end
      wr(DIAG_OFS, DIAG_RST);
      // fixed corner cases first, then random ones within legal limits
      for (int i = 0; i < 16; i++) begin
         x = (i < 8) ? tx[i] : int'($urandom_range(0, 8191)) - 4096;
         trw = (i < 8) ? tt[i] : 24'($urandom);
         clw = (i < 8) ? tc[i] : {12'($urandom_range(0, 2047)),
                                  12'($urandom_range(2048, 4095))};
         wr(TRIM_OFS, trw);
         wr(CLAMP_OFS, clw);
         sample <= 13'(x);
         rd(TRIM_OFS, v); chk("trim_rb", v, trw);
         rd(CLAMP_OFS, v); chk("clamp_rb", v, clw);
         pulses(1);
         v = 24'(model(x, trw, clw));
         chk("out_data", out.data, v);
      end
      wr(CLAMP_OFS, CLAMP_RST);
      // self-test request under frequency 3 gives one on-period only
      repeat (100) @(posedge clk);
      #1;
      chk("coil_idle", coil_on, 1'b0);
      chk("sel_idle", diag_sel, 1'b0);
      wr(DIAG_OFS, DIAG_RST | 24'h10);
      wr(CTRL_OFS, 24'h1);
      phase(lvl, n);
      phase(lvl, n); chk("req_on", n, ON_N);
      repeat (200) @(posedge clk);
      #1;
      chk("req_once", coil_on, 1'b0);
      for (int f = 1; f < 3; f++) begin
         wr(DIAG_OFS, 24'h10 | 24'(f << FREQ_LSB));
         phase(lvl, n);
         repeat (3) begin
            phase(lvl, n);
            x = lvl ? ON_N : (f == 1 ? OFF1_N : OFF2_N);
            chk("coil_len", n, x);
         end
      end
      // frequency 0 keeps the path swapping; disable stops compensation
      for (int k = 0; k < 2; k++) begin
         wr(DIAG_OFS, k ? 24'h90 : 24'h10);
         repeat (5) @(posedge clk);
         n = 0;
         s = 0;
         repeat (400) begin
            @(posedge clk);
            #1;
            if (comp_en !== (coil_on & (k == 0))) n++;
            if (diag_sel === 1'b1) s++;
         end
         chk("comp_en", n, 0);
         chk("diag_swap", s > 0 && s < 400, 1'b1);
      end
      // ten percent is the limit; suppression hides the coil fault
      for (int k = 0; k < 4; k++) begin
         resp <= dr[k];
         wr(DIAG_OFS, dw[k]);
         wr(STAT_OFS, 24'h1f);
         pulses(4);
         chk("coil_err", out.err, (k == 1 || k == 2));
         chk("coil_hiz", out.hiz, (k == 2));
      end
      chk("frames", frames > 20, 1'b1);
      chk("frame_gap", gap_err, 0);
      results();
   end
endmodule
